// ---- bench/data_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// data memory behind the indirect port, combinational read
module data_mem_model
   import pc_stack_pkg::*;
(
   // clock
   input wire logic pclk,
   // access from the block
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [EFF_W-1:0] mem_addr,
   input wire logic [DATA_W-1:0] mem_wdata,
   output logic [DATA_W-1:0] mem_rdata
);
   logic [DATA_W-1:0] ram [512]; // full 9-bit space
   // seeded pattern so a missed write shows up
   initial begin
      for (int i = 0; i < 512; i++) ram[i] = 8'(i) ^ 8'h5A;
   end
   // write only on a real request
   always @(posedge pclk) begin
      if (mem_req && mem_we) ram[mem_addr] <= mem_wdata;
   end
   // outside a request the bus shows junk, not the last value
   always_comb mem_rdata = mem_req ? ram[mem_addr] : ~ram[mem_addr];
endmodule // data_mem_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pc_stack_pkg::*;
   localparam logic [PC_W-1:0] IRQV = 13'h0040; // entry address used here
   logic pclk, presetn, psel, penable, pwrite, op_step, pready, pslverr;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata, rd;
   logic er, mem_req, mem_we;
   logic [4:0] ops; // irq, call, goto, return, pcl write
   logic [ABS_W-1:0] instr_addr;
   logic [DATA_W-1:0] pcl_data, mem_wdata, mem_rdata;
   logic [PC_W-1:0] pc_out;
   logic [EFF_W-1:0] mem_addr;
   int err_count, checked;
   // register rows: offset, write data, readback, error
   typedef struct {logic [7:0] a; logic [31:0] d, x; logic e;} row_t;
   row_t rows [5] = '{'{OFF_HIGH_LATCH, 32'hFFFFFFFF, 32'h0000001F, 1'b0},
      '{OFF_FILE_PTR, 32'h000001A5, 32'h000000A5, 1'b0},
      '{OFF_STATUS, 32'h000000FF, 32'h00000080, 1'b0},
      '{OFF_STATUS, 32'h0000007F, 32'h00000000, 1'b0},
      '{8'h14, 32'h00000055, 32'h00000000, 1'b1}};
   pc_stack_indirect_addr #(.IRQ_VECTOR(IRQV)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .op_step(op_step), .op_goto(ops[2]),
      .op_call(ops[3]), .op_return(ops[1]), .op_irq(ops[4]),
      .op_pcl_we(ops[0]), .instr_addr(instr_addr), .pcl_data(pcl_data),
      .pc_out(pc_out), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   data_mem_model mem (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
         err_count++;
      end
   endtask
   // one apb transfer, result left in rd and er
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // look mid-cycle, where pready and prdata have settled for the
      // coming edge; sampling right at the edge races the sequencer
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      // the edge at which pready is taken high, then release
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask
   // one decoder op for one cycle, pc sampled after it lands
   task automatic op(input logic [4:0] v, input logic [10:0] a,
                     input logic [7:0] d);
      @(posedge pclk);
      ops <= v;
      instr_addr <= a;
      pcl_data <= d;
      @(posedge pclk);
      ops <= 5'h00;
      #1;
   endtask
   // verdict, the one place the run ends
   task automatic final_report;
      $display("errors=%0d checks=%0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // watchdog, far beyond the roughly 160 cycles the tests need
   initial begin
      #(25 * 5000);
      err_count++;
      final_report;
   end
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, op_step, ops} = '0;
      {paddr, pwdata, instr_addr, pcl_data} = '0;
      err_count = 0;
      checked = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk(32'(pc_out), 32'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].x);
         chk(32'(er), 32'(rows[i].e));
      end
      // software pc write takes the whole latch
      apb(1'b1, OFF_HIGH_LATCH, 32'h1A);
      apb(1'b1, OFF_PC_LOW, 32'h5C);
      #1 chk(32'(pc_out), 32'h1A5C);
      apb(1'b0, OFF_PC_LOW, 32'h0);
      chk(rd, 32'h5C);
      op(5'b00100, 11'h123, 8'h00);
      chk(32'(pc_out), 32'h1923);
      op(5'b01000, 11'h045, 8'h00);
      chk(32'(pc_out), 32'h1845);
      op(5'b00010, 11'h000, 8'h00);
      chk(32'(pc_out), 32'h1924);
      apb(1'b0, OFF_HIGH_LATCH, 32'h0);
      chk(rd, 32'h1A);
      // computed jump keeps the block, no carry upward
      op(5'b00001, 11'h000, 8'hFF);
      chk(32'(pc_out), 32'h1AFF);
      op(5'b00001, 11'h000, 8'h01);
      chk(32'(pc_out), 32'h1A01);
      op(5'b10000, 11'h000, 8'h00);
      chk(32'(pc_out), 32'(IRQV));
      op(5'b00010, 11'h000, 8'h00);
      chk(32'(pc_out), 32'h1A01);
      // nine calls then nine returns: the ninth overwrote the first
      apb(1'b1, OFF_HIGH_LATCH, 32'h0);
      op(5'b00100, 11'h000, 8'h00);
      for (int k = 1; k <= 9; k++) op(5'b01000, 11'(k * 16), 8'h00);
      for (int j = 0; j < 9; j++) begin
         op(5'b00010, 11'h000, 8'h00);
         chk(32'(pc_out), ((j < 8 ? 9 - j : 9) - 1) * 16 + 1);
      end
      // indirect access in both banks
      apb(1'b1, OFF_FILE_PTR, 32'h25);
      apb(1'b1, OFF_STATUS, 32'h80);
      apb(1'b1, OFF_IND_PORT, 32'hA7);
      chk(32'(mem.ram[9'h125]), 32'hA7);
      apb(1'b0, OFF_IND_PORT, 32'h0);
      chk(rd, 32'hA7);
      apb(1'b1, OFF_STATUS, 32'h00);
      apb(1'b0, OFF_IND_PORT, 32'h0);
      chk(rd, 32'h7F);
      // pointer aimed at the port itself
      apb(1'b1, OFF_FILE_PTR, 32'h00);
      apb(1'b0, OFF_IND_PORT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, OFF_IND_PORT, 32'h33);
      chk(32'(mem.ram[9'h000]), 32'h5A);
      // reset in mid-run clears pc at once
      @(posedge pclk);
      presetn <= 1'b0;
      #1 chk(32'(pc_out), 32'h0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // after release: pc and latch cleared, sequential step counts
      #1 chk(32'(pc_out), 32'h0);
      apb(1'b0, OFF_HIGH_LATCH, 32'h0);
      chk(rd, 32'h0);
      @(posedge pclk);
      op_step <= 1'b1;
      @(posedge pclk);
      op_step <= 1'b0;
      #1 chk(32'(pc_out), 32'h1);
      final_report;
   end
endmodule // testbench
`default_nettype wire

// ---- design/pc_stack_indirect_addr.sv ----
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect_addr
   import pc_stack_pkg::*;
#(
   // interrupt entry address, plain default
   parameter logic [PC_W-1:0] IRQ_VECTOR = 13'h0004,
   // stack depth, must be a power of two for the wrap
   parameter int DEPTH = STK_DEPTH
)(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction decoder requests
   input wire logic op_step,
   input wire logic op_goto,
   input wire logic op_call,
   input wire logic op_return,
   input wire logic op_irq,
   input wire logic op_pcl_we,
   input wire logic [ABS_W-1:0] instr_addr,
   input wire logic [DATA_W-1:0] pcl_data,
   // program counter
   output logic [PC_W-1:0] pc_out,
   // data memory master for indirect access
   output logic mem_req,
   output logic mem_we,
   output logic [EFF_W-1:0] mem_addr,
   output logic [DATA_W-1:0] mem_wdata,
   input wire logic [DATA_W-1:0] mem_rdata
);
   localparam int SP_W = $clog2(DEPTH);
   localparam logic [SP_W-1:0] SP_ONE = {{(SP_W-1){1'b0}}, 1'b1};
   localparam logic [SP_W-1:0] SP_RESET = {SP_W{1'b0}};

   logic [PC_W-1:0] pc_reg; // program counter
   logic [PC_W-1:0] pc_next;
   logic [LATCH_W-1:0] latch_reg; // pc high latch
   logic [DATA_W-1:0] fp_reg; // file pointer
   logic bank_reg; // bank select for indirect
   logic [PC_W-1:0] stack_reg [DEPTH]; // return stack
   logic [SP_W-1:0] sp_reg; // next free slot
   logic [SP_W-1:0] sp_top; // slot of last push
   logic [PC_W-1:0] push_val;
   ind_state_t state_reg; // indirect sequencer
   logic ind_self_reg; // pointer aimed at the port itself
   logic [APB_DW-1:0] prdata_reg;
   logic mem_req_reg;
   logic mem_we_reg;
   logic [EFF_W-1:0] mem_addr_reg;
   logic [DATA_W-1:0] mem_wdata_reg;
   // decode and strobes
   logic access_ph, setup_ph;
   logic sel_pcl, sel_latch, sel_fp, sel_stat, sel_ind, mapped;
   logic apb_wr, ind_self;
   // gated core operations
   logic irq_go, call_go, goto_go, ret_go, cpcl_go, apcl_go, step_go;
   logic push_go, pop_go;

   assign access_ph = psel & penable;
   assign setup_ph = psel & ~penable;

   // address decode; stack pointer has no offset at all
   always_comb begin
      sel_pcl = 1'b0;
      sel_latch = 1'b0;
      sel_fp = 1'b0;
      sel_stat = 1'b0;
      sel_ind = 1'b0;
      if (paddr == OFF_PC_LOW) begin
         sel_pcl = 1'b1;
      end else if (paddr == OFF_HIGH_LATCH) begin
         sel_latch = 1'b1;
      end else if (paddr == OFF_FILE_PTR) begin
         sel_fp = 1'b1;
      end else if (paddr == OFF_STATUS) begin
         sel_stat = 1'b1;
      end else if (paddr == OFF_IND_PORT) begin
         sel_ind = 1'b1;
      end
   end
   assign mapped = sel_pcl | sel_latch | sel_fp | sel_stat | sel_ind;

   // indirect accesses wait for the memory, all others answer at once
   assign pready = ~sel_ind | (state_reg == ST_DONE);
   // unmapped offsets fail, writes ignored, read zero
   assign pslverr = access_ph & ~mapped;
   assign apb_wr = access_ph & pready & pwrite & mapped;
   // port aimed at itself through the bank-local file bits
   assign ind_self = (fp_reg[FILE_W-1:0] == IND_PORT_FILE);

   // one pc change per cycle; interrupt entry wins over everything
   assign irq_go = op_irq;
   assign call_go = op_call & ~op_irq;
   assign goto_go = op_goto & ~op_irq & ~op_call;
   assign ret_go = op_return & ~op_irq & ~op_call & ~op_goto;
   assign cpcl_go = op_pcl_we & ~(op_irq | op_call | op_goto | op_return);
   // software write loses to any decoder jump in the same cycle
   assign apcl_go = apb_wr & sel_pcl
      & ~(op_irq | op_call | op_goto | op_return | op_pcl_we);
   assign step_go = op_step & ~(op_irq | op_call | op_goto | op_return
      | op_pcl_we | (apb_wr & sel_pcl));
   assign push_go = irq_go | call_go;
   assign pop_go = ret_go;
   assign sp_top = sp_reg - SP_ONE;
   // call returns past itself, interrupt resumes the skipped one
   assign push_val = irq_go ? pc_reg : pc_reg + PC_ONE;

   // pc next value; upper bits come from the latch, the stack, the interrupt vector or the step carry
   always_comb begin
      pc_next = pc_reg;
      if (irq_go) begin
         pc_next = IRQ_VECTOR;
      end else if (call_go | goto_go) begin
         // top two from latch, eleven from instruction
         pc_next = {latch_reg[LATCH_ABS_HI:LATCH_ABS_LO], instr_addr};
      end else if (ret_go) begin
         pc_next = stack_reg[sp_top];
      end else if (cpcl_go) begin
         // alu result, no carry into the top
         pc_next = {latch_reg, pcl_data};
      end else if (apcl_go) begin
         pc_next = {latch_reg, pwdata[DATA_W-1:0]};
      end else if (step_go) begin
         pc_next = pc_reg + PC_ONE;
      end
   end

   // program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_reg <= PC_RESET;
      end else begin
         pc_reg <= pc_next;
      end
   end
   assign pc_out = pc_reg;

   // high latch, only software touches it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= LATCH_RESET;
      end else if (apb_wr & sel_latch) begin
         latch_reg <= pwdata[LATCH_W-1:0];
      end
   end

   // file pointer and bank bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fp_reg <= FP_RESET;
         bank_reg <= BANK_RESET;
      end else begin
         if (apb_wr & sel_fp) begin
            fp_reg <= pwdata[DATA_W-1:0];
         end
         if (apb_wr & sel_stat) begin
            bank_reg <= pwdata[BANK_BIT];
         end
      end
   end

   // return stack; pointer wraps, no flag kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg <= SP_RESET;
         for (int i = 0; i < DEPTH; i++) begin
            stack_reg[i] <= PC_RESET;
         end
      end else if (push_go) begin
         stack_reg[sp_reg] <= push_val;
         sp_reg <= sp_reg + SP_ONE;
      end else if (pop_go) begin
         sp_reg <= sp_top;
      end
   end

   // indirect sequencer: issue, wait one cycle, answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (access_ph & sel_ind) begin
                  state_reg <= ST_MEM;
               end
            end
            ST_MEM: begin
               state_reg <= ST_DONE;
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // memory request; self-aimed access never reaches memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_addr_reg <= {EFF_W{1'b0}};
         mem_wdata_reg <= BYTE_ZERO;
         ind_self_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && access_ph && sel_ind) begin
         mem_req_reg <= ~ind_self;
         mem_we_reg <= pwrite;
         mem_addr_reg <= {bank_reg, fp_reg};
         mem_wdata_reg <= pwdata[DATA_W-1:0];
         ind_self_reg <= ind_self;
      end else begin
         mem_req_reg <= 1'b0;
      end
   end
   assign mem_req = mem_req_reg;
   assign mem_we = mem_we_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;

   // read data, captured in setup so it is stable through access; indirect port data captured in the memory state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= RD_ZERO;
      end else if (state_reg == ST_MEM) begin
         prdata_reg <= RD_ZERO;
         if (!ind_self_reg) begin
            prdata_reg[DATA_W-1:0] <= mem_rdata;
         end
      end else if (setup_ph) begin
         prdata_reg <= RD_ZERO;
         if (sel_pcl) begin
            prdata_reg[DATA_W-1:0] <= pc_reg[DATA_W-1:0];
         end else if (sel_latch) begin
            prdata_reg[LATCH_W-1:0] <= latch_reg;
         end else if (sel_fp) begin
            prdata_reg[DATA_W-1:0] <= fp_reg;
         end else if (sel_stat) begin
            prdata_reg[BANK_BIT] <= bank_reg;
         end
      end
   end
   assign prdata = prdata_reg;

   // checks
   AST_PC_RESET: assert property (
      @(posedge pclk) !presetn |-> pc_reg == PC_RESET)
      else $error("pc not cleared under reset");
   AST_PCL_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      apcl_go |=> pc_reg == {$past(latch_reg), $past(pwdata[DATA_W-1:0])})
      else $error("low byte write did not load pc from latch");
   AST_ABS_JUMP: assert property (
      @(posedge pclk) disable iff (!presetn)
      goto_go |=> pc_reg[PC_W-1:ABS_W] ==
         $past(latch_reg[LATCH_ABS_HI:LATCH_ABS_LO])
         && pc_reg[ABS_W-1:0] == $past(instr_addr))
      else $error("absolute jump target wrong");
   AST_COMPUTED: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpcl_go |=> pc_reg[PC_W-1:DATA_W] == $past(latch_reg)
         && pc_reg[DATA_W-1:0] == $past(pcl_data))
      else $error("computed jump carried or lost latch");
   AST_CALL_RET: assert property (
      @(posedge pclk) disable iff (!presetn)
      call_go ##1 ret_go |=> pc_reg == $past(pc_reg, 2) + PC_ONE)
      else $error("return did not resume after call");
   AST_IRQ_ENTRY: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq_go |=> pc_reg == IRQ_VECTOR
         && stack_reg[$past(sp_reg)] == $past(pc_reg))
      else $error("interrupt entry push or vector wrong");
   AST_LATCH_KEEP: assert property (
      @(posedge pclk) disable iff (!presetn)
      (push_go || pop_go) && !(apb_wr && sel_latch) |=> $stable(latch_reg))
      else $error("stack operation changed latch");
   AST_WRAP: assert property (
      @(posedge pclk) disable iff (!presetn)
      push_go && sp_reg == {SP_W{1'b1}} |=> sp_reg == SP_RESET)
      else $error("stack pointer did not wrap");
   AST_SELF_READ: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_reg == ST_MEM && ind_self_reg |=> prdata_reg == RD_ZERO)
      else $error("self-aimed indirect read not zero");
   AST_SELF_NOSTORE: assert property (
      @(posedge pclk) disable iff (!presetn)
      mem_req_reg |-> mem_addr_reg[FILE_W-1:0] != IND_PORT_FILE)
      else $error("self-aimed indirect reached memory");
   AST_EFF_ADDR: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && access_ph && sel_ind && !ind_self
      |=> mem_req_reg && mem_addr_reg == {$past(bank_reg), $past(fp_reg)})
      else $error("indirect address not bank and pointer");
   COV_CALL_RET: cover property (
      @(posedge pclk) disable iff (!presetn) call_go ##1 ret_go);
   COV_WRAP: cover property (
      @(posedge pclk) disable iff (!presetn)
      push_go && sp_reg == {SP_W{1'b1}});
   COV_IND_READ: cover property (
      @(posedge pclk) disable iff (!presetn)
      state_reg == ST_DONE && !ind_self_reg && !pwrite);
   COV_GOTO: cover property (
      @(posedge pclk) disable iff (!presetn) goto_go);
endmodule // pc_stack_indirect_addr
`default_nettype wire

// ---- design/pc_stack_pkg.sv ----
package pc_stack_pkg;
   // datapath widths
   localparam int PC_W = 13;
   localparam int DATA_W = 8;
   localparam int LATCH_W = 5;
   localparam int ABS_W = 11;
   localparam int EFF_W = 9;
   localparam int FILE_W = 7;
   localparam int STK_DEPTH = 8;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   // latch bits feeding the pc top on absolute jumps
   localparam int LATCH_ABS_HI = 4;
   localparam int LATCH_ABS_LO = 3;
   // bank select bit inside the status register
   localparam int BANK_BIT = 7;
   // register byte offsets
   localparam logic [APB_AW-1:0] OFF_PC_LOW = 8'h00;
   localparam logic [APB_AW-1:0] OFF_HIGH_LATCH = 8'h04;
   localparam logic [APB_AW-1:0] OFF_FILE_PTR = 8'h08;
   localparam logic [APB_AW-1:0] OFF_STATUS = 8'h0C;
   localparam logic [APB_AW-1:0] OFF_IND_PORT = 8'h10;
   // reset values
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
   localparam logic [DATA_W-1:0] FP_RESET = 8'h00;
   localparam logic BANK_RESET = 1'b0;
   // misc constants
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   localparam logic [FILE_W-1:0] IND_PORT_FILE = 7'h00;
   localparam logic [APB_DW-1:0] RD_ZERO = 32'h00000000;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   // indirect access sequencer
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MEM = 3'b010,
      ST_DONE = 3'b100
   } ind_state_t;
endpackage
